// ==== pcscs_regs.sv ====
/*
 * 100 mb/s pcs configuration and status register bank behind an apb
 * slave, with the datapath controls, link qualification, forced-mode
 * crossover and the descrambler timeout watchdog.
 * assumes: all inputs synchronous to clk_i; the fiber strap is stable
 * around reset release; soft reset arrives as a one-cycle pulse.
 */
// Function
// - crossover bit toggles pair assignment while speed and mdix are forced and link is down
// - bit 11 set gives free-running receive clock, else phase aligned
// - bit 10 set puts the 100 mb/s transmitter in silent mode
// - bit 9 set forces signal detect active
// - hold bit one: link survives lock loss while signal stays valid
// - hold bit zero: link drops on signal loss or lock loss
// - descrambler timeout 722 us, or 2 ms with bit 7 set
// - bit 6 enables fiber mode at the next soft reset, reset value from fiber strap
// - bit 5 forces good 100 mb/s link, ORed with mac input
// - bit 4 reads zero and ignores writes
// - bit 3 enables far-end fault indication, strap sets it
// - bit 2 bypasses nrzi coding, reset zero
// - bit 1 skips transmit scrambler, strap sets it
// - bit 0 skips receive descrambler, strap sets it
// - paged addresses 0x14-0x1f follow page select; page 0 holds this
`timescale 1ns/1ps
`include "pcscs_defines.svh"

module pcscs_regs #(
    parameter int DESC_SHORT_CYC =
        `PCSCS_DESC_SHORT_NS * `PCSCS_CLK_MHZ / 1000,
    parameter int DESC_LONG_CYC =
        `PCSCS_DESC_LONG_NS * `PCSCS_CLK_MHZ / 1000,
    parameter int XOVER_CYC = `PCSCS_XOVER_NS * `PCSCS_CLK_MHZ / 1000
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // strap and neighbouring control state
    input wire logic fiber_strap_i,
    input wire logic soft_reset_i,
    input wire logic autoneg_enable_i,
    input wire logic auto_mdix_enable_i,
    input wire logic mac_side_link_force_input_i,
    // receive-side status from the pma and descrambler
    input wire logic signal_level_valid_i,
    input wire logic descr_lock_i,
    input wire logic descr_idle_seen_i,
    // datapath controls
    output logic mdix_select_o,
    output logic rx_clk_free_run_o,
    output logic tx_silent_mode_enable_o,
    output logic signal_detect_o,
    output logic descrambler_timeout_long_o,
    output logic fiber_mode_enable_o,
    output logic force_100_link_o,
    output logic far_fault_indication_enable_o,
    output logic nrzi_bypass_o,
    output logic tx_whitening_skip_o,
    output logic rx_dewhitening_skip_o,
    output logic link_up_o
);

    localparam logic [`PCSCS_XCNT_W-1:0] XOVER_LIM =
        `PCSCS_XCNT_W'(XOVER_CYC - 1);

    // refuse a crossover period the counter cannot hold
    if (XOVER_CYC < 1 || XOVER_CYC >= (1 << `PCSCS_XCNT_W))
    begin : g_bad_xover
        $error("crossover period out of counter range");
    end

    pcscs_pkg::pcscs_regs_s st_ff;
    pcscs_pkg::pcscs_regs_s nxt_st;
    logic desc_expired;
    logic eff_lock;
    logic sd_level;
    logic setup;
    logic wr_acc;
    logic [9:0] idx;

    // word index of an aligned byte address, all ones when misaligned
    function automatic logic [9:0] word_index(input logic [11:0] a);
        word_index = (a[1:0] == 2'b00) ? a[11:2] : 10'h3ff;
    endfunction

    // true when the index is served at the present page
    function automatic logic hit(input logic [9:0] i,
                                 input logic [2:0] pg);
        logic paged;
        paged = (i >= `PCSCS_PAGED_LO) && (i <= `PCSCS_PAGED_HI);
        if (i == `PCSCS_IDX_PAGESEL || i == `PCSCS_IDX_STATUS) begin
            hit = 1'b1;
        end else if (i == `PCSCS_IDX_CFG) begin
            hit = paged && (pg == `PCSCS_PAGE_EXT0);
        end else begin
            hit = 1'b0;
        end
    endfunction

    // byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb,
                                          input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old & ~lanes) | (wd[15:0] & lanes);
    endfunction

    pcscs_desc_wdog #(
        .SHORT_CYC(DESC_SHORT_CYC),
        .LONG_CYC(DESC_LONG_CYC)
    ) u_wdog (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .lock_i(descr_lock_i),
        .idle_seen_i(descr_idle_seen_i),
        .long_i(st_ff.cfg[`PCSCS_B_DESC_LONG]),
        .expired_o(desc_expired)
    );

    // lock as the link sees it, signal level with its override
    assign eff_lock = descr_lock_i & ~desc_expired;
    assign sd_level = signal_level_valid_i |
                      st_ff.cfg[`PCSCS_B_SD_OVR];
    assign idx = word_index(paddr_i);
    assign setup = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pwrite_i & ~st_ff.err;

    // next state: bus, strap capture, link, crossover, outputs
    always_comb begin
        nxt_st = st_ff;

        // read data and error decided in setup, held through access
        if (setup) begin
            nxt_st.err = ~hit(idx, st_ff.page);
            nxt_st.rdata = 32'h0000_0000;
            if (pwrite_i) begin
                nxt_st.rdata = 32'h0000_0000;
            end else if (idx == `PCSCS_IDX_PAGESEL) begin
                nxt_st.rdata = {29'h0, st_ff.page};
            end else if (idx == `PCSCS_IDX_STATUS) begin
                nxt_st.rdata = {26'h0, st_ff.fiber_act, desc_expired,
                                eff_lock, sd_level, st_ff.mdix,
                                st_ff.link == pcscs_pkg::PCSCS_LINK_UP};
            end else if (hit(idx, st_ff.page)) begin
                nxt_st.rdata = {16'h0, st_ff.cfg};
            end
        end

        // writes land at the access edge; strobed bits other than cfg bit 4 stored as written
        if (wr_acc && idx == `PCSCS_IDX_PAGESEL && pstrb_i[0]) begin
            nxt_st.page = pwdata_i[2:0];
        end
        if (wr_acc && idx == `PCSCS_IDX_CFG) begin
            nxt_st.cfg = merge(st_ff.cfg, pwdata_i, pstrb_i,
                               `PCSCS_CFG_WMASK);
        end

        // strap is caught on the first edge after reset release, so
        // the asynchronous reset itself loads constants only
        if (!st_ff.strap_done) begin
            nxt_st.strap_done = 1'b1;
            nxt_st.cfg = (`PCSCS_CFG_RESET & ~`PCSCS_CFG_STRAP) |
                         ({16{fiber_strap_i}} &
                          `PCSCS_CFG_STRAP);
            nxt_st.fiber_act = fiber_strap_i;
        end else if (soft_reset_i) begin
            // fiber mode is a media change, applied only on soft reset
            nxt_st.fiber_act = st_ff.cfg[`PCSCS_B_FIBER];
        end

        // link qualification
        case (st_ff.link)
            pcscs_pkg::PCSCS_LINK_DOWN: begin
                if (sd_level && eff_lock) begin
                    nxt_st.link = pcscs_pkg::PCSCS_LINK_UP;
                end
            end
            pcscs_pkg::PCSCS_LINK_UP: begin
                if (!sd_level) begin
                    nxt_st.link = pcscs_pkg::PCSCS_LINK_DOWN;
                end else if (!st_ff.cfg[`PCSCS_B_HOLD] && !eff_lock) begin
                    nxt_st.link = pcscs_pkg::PCSCS_LINK_DOWN;
                end
            end
            default: begin
                nxt_st.link = pcscs_pkg::PCSCS_LINK_DOWN;
            end
        endcase

        // crossover hunt only while forced, link down; hold once up
        if (st_ff.cfg[`PCSCS_B_XOVER] && !autoneg_enable_i &&
            !auto_mdix_enable_i &&
            st_ff.link == pcscs_pkg::PCSCS_LINK_DOWN) begin
            if (st_ff.xcnt >= XOVER_LIM) begin
                nxt_st.xcnt = '0;
                nxt_st.mdix = ~st_ff.mdix;
            end else begin
                nxt_st.xcnt = st_ff.xcnt + `PCSCS_XCNT_W'(1);
            end
        end else if (!st_ff.cfg[`PCSCS_B_XOVER]) begin
            nxt_st.xcnt = '0;
            nxt_st.mdix = 1'b0;
        end else begin
            nxt_st.xcnt = '0;
        end

        // registered versions of the combined indications
        nxt_st.sd_out = sd_level;
        nxt_st.force_out = st_ff.cfg[`PCSCS_B_FORCE100] |
                           mac_side_link_force_input_i;
    end

    // whole state in one register; constants only under reset
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_ff <= '{cfg: `PCSCS_CFG_RESET,
                       page: `PCSCS_PAGE_EXT0,
                       link: pcscs_pkg::PCSCS_LINK_DOWN,
                       xcnt: '0,
                       mdix: 1'b0,
                       fiber_act: 1'b0,
                       strap_done: 1'b0,
                       sd_out: 1'b0,
                       force_out: 1'b0,
                       rdata: 32'h0000_0000,
                       err: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // zero wait state slave; data and error come from flops
    assign pready_o = 1'b1;
    assign prdata_o = st_ff.rdata;
    assign pslverr_o = psel_i & penable_i & st_ff.err;

    // datapath controls straight from the register, no added delay
    assign mdix_select_o = st_ff.mdix;
    assign rx_clk_free_run_o = st_ff.cfg[`PCSCS_B_FREE_CLK];
    assign tx_silent_mode_enable_o = st_ff.cfg[`PCSCS_B_SILENT];
    assign signal_detect_o = st_ff.sd_out;
    assign descrambler_timeout_long_o =
        st_ff.cfg[`PCSCS_B_DESC_LONG];
    assign fiber_mode_enable_o = st_ff.fiber_act;
    assign force_100_link_o = st_ff.force_out;
    assign far_fault_indication_enable_o =
        st_ff.cfg[`PCSCS_B_FAR_FAULT];
    assign nrzi_bypass_o = st_ff.cfg[`PCSCS_B_NRZI_SKIP];
    assign tx_whitening_skip_o = st_ff.cfg[`PCSCS_B_TX_SKIP];
    assign rx_dewhitening_skip_o = st_ff.cfg[`PCSCS_B_RX_SKIP];
    // all controls above are flops; the cfg bits update at the write edge
    assign link_up_o = (st_ff.link == pcscs_pkg::PCSCS_LINK_UP) |
                       st_ff.force_out;

endmodule

// ==== pcscs_defines.svh ====
/*
 * offsets, field positions, reset values and timing counts of the
 * 100 Mb/s pcs configuration and status register bank.
 * assumes: included by bare name by the package and the modules.
 */
`ifndef PCSCS_DEFINES_SVH
`define PCSCS_DEFINES_SVH

// register indices; byte address is four times the index
`define PCSCS_IDX_PAGESEL 10'h013
`define PCSCS_IDX_CFG 10'h016
`define PCSCS_IDX_STATUS 10'h020
`define PCSCS_PAGED_LO 10'h014
`define PCSCS_PAGED_HI 10'h01f
`define PCSCS_PAGE_EXT0 3'h0

// configuration field positions
`define PCSCS_B_XOVER 15
`define PCSCS_B_FREE_CLK 11
`define PCSCS_B_SILENT 10
`define PCSCS_B_SD_OVR 9
`define PCSCS_B_HOLD 8
`define PCSCS_B_DESC_LONG 7
`define PCSCS_B_FIBER 6
`define PCSCS_B_FORCE100 5
`define PCSCS_B_FAR_FAULT 3
`define PCSCS_B_NRZI_SKIP 2
`define PCSCS_B_TX_SKIP 1
`define PCSCS_B_RX_SKIP 0

// reset value, writable bits, strap-driven bits
`define PCSCS_CFG_RESET 16'h0100
`define PCSCS_CFG_WMASK 16'hffef
`define PCSCS_CFG_STRAP 16'h004b

// timing: clock rate and times in their own units
`define PCSCS_CLK_MHZ 250
`define PCSCS_DESC_SHORT_NS 722000
`define PCSCS_DESC_LONG_NS 2000000
`define PCSCS_XOVER_NS 100000
`define PCSCS_WD_W 20
`define PCSCS_XCNT_W 24

`endif

// ==== pcscs_pkg.sv ====
/*
 * types of the pcs configuration and status register bank: link state
 * enum and the state structs of both modules.
 * assumes: pcscs_defines.svh sets the counter widths.
 */
`include "pcscs_defines.svh"

package pcscs_pkg;

    // link qualification state, one-hot
    typedef enum logic [1:0] {
        PCSCS_LINK_DOWN = 2'b01,
        PCSCS_LINK_UP = 2'b10
    } pcscs_link_e;

    // whole state of the register bank
    typedef struct packed {
        logic [15:0] cfg;
        logic [2:0] page;
        pcscs_link_e link;
        logic [`PCSCS_XCNT_W-1:0] xcnt;
        logic mdix;
        logic fiber_act;
        logic strap_done;
        logic sd_out;
        logic force_out;
        logic [31:0] rdata;
        logic err;
    } pcscs_regs_s;

    // whole state of the descrambler watchdog
    typedef struct packed {
        logic [`PCSCS_WD_W-1:0] cnt;
        logic expired;
    } pcscs_wdog_s;

endpackage

// ==== pcscs_desc_wdog.sv ====
/*
 * descrambler lock watchdog: flags loss of lock when no idle is seen
 * within the selected timeout.
 * assumes: inputs synchronous to clk_i; limits fit the counter width.
 */
`timescale 1ns/1ps
`include "pcscs_defines.svh"

module pcscs_desc_wdog #(
    parameter int SHORT_CYC = 180500,
    parameter int LONG_CYC = 500000
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic lock_i,
    input wire logic idle_seen_i,
    input wire logic long_i,
    output logic expired_o
);

    localparam logic [`PCSCS_WD_W-1:0] SHORT_LIM =
        `PCSCS_WD_W'(SHORT_CYC - 1);
    localparam logic [`PCSCS_WD_W-1:0] LONG_LIM =
        `PCSCS_WD_W'(LONG_CYC - 1);

    // refuse a long limit the counter cannot reach and any limit below one
    if (LONG_CYC >= (1 << `PCSCS_WD_W) || SHORT_CYC < 1 ||
        LONG_CYC < 1) begin : g_bad_limit
        $error("watchdog limit out of counter range");
    end

    pcscs_pkg::pcscs_wdog_s st_ff;
    pcscs_pkg::pcscs_wdog_s nxt_st;
    logic [`PCSCS_WD_W-1:0] lim;

    // timer restarts on every idle; expiry holds until lock drops
    always_comb begin
        nxt_st = st_ff;
        lim = long_i ? LONG_LIM : SHORT_LIM;
        if (!lock_i) begin
            nxt_st.cnt = '0;
            nxt_st.expired = 1'b0;
        end else if (idle_seen_i) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt >= lim) begin
            nxt_st.expired = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + `PCSCS_WD_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign expired_o = st_ff.expired;

endmodule

// ==== pcscs_regs_assertions.sv ====
/*
 * concurrent checks of the pcs configuration register bank ports.
 * assumes: bound to pcscs_regs; zero-wait apb, cfg at byte 0x058.
 */
`timescale 1ns/1ps

module pcscs_regs_assertions (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    input wire logic soft_reset_i,
    input wire logic autoneg_enable_i,
    input wire logic auto_mdix_enable_i,
    input wire logic mac_side_link_force_input_i,
    input wire logic signal_level_valid_i,
    input wire logic descr_lock_i,
    input wire logic mdix_select_o,
    input wire logic rx_clk_free_run_o,
    input wire logic tx_silent_mode_enable_o,
    input wire logic signal_detect_o,
    input wire logic fiber_mode_enable_o,
    input wire logic force_100_link_o,
    input wire logic rx_dewhitening_skip_o,
    input wire logic link_up_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic wacc;
    logic racc;
    // accesses to the config word, writes only when accepted (a paged miss errors)
    assign wacc = psel_i && penable_i && pwrite_i && paddr_i == 12'h058
        && !pslverr_o;
    assign racc = psel_i && penable_i && !pwrite_i && paddr_i == 12'h058;

    free_clk_a: assert property (
        wacc && pstrb_i[1] |=> rx_clk_free_run_o == $past(pwdata_i[11]))
        else $error("free clock bit not taken from write");
    silent_tx_a: assert property (
        wacc && pstrb_i[1] |=> tx_silent_mode_enable_o == $past(pwdata_i[10]))
        else $error("silent mode bit not taken from write");
    rx_skip_a: assert property (
        wacc && pstrb_i[0] |=> rx_dewhitening_skip_o == $past(pwdata_i[0]))
        else $error("descrambler skip bit not taken from write");
    sd_force_a: assert property (
        signal_level_valid_i |=> signal_detect_o)
        else $error("signal detect low while level valid");
    mac_force_a: assert property (
        mac_side_link_force_input_i |=> force_100_link_o)
        else $error("mac force not reflected");
    link_force_a: assert property (
        force_100_link_o |-> link_up_o)
        else $error("forced link not shown as up");
    link_rise_a: assert property (
        $rose(link_up_o) |-> force_100_link_o || $past(descr_lock_i))
        else $error("link came up without lock");
    xover_hunt_a: assert property (
        $rose(mdix_select_o) |-> !$past(autoneg_enable_i)
            && !$past(auto_mdix_enable_i))
        else $error("crossover toggled under automatic modes");
    rsvd_bit_a: assert property (
        racc |-> prdata_o[4] == 1'b0)
        else $error("reserved bit read as one");
    paged_miss_a: assert property (
        psel_i && penable_i && paddr_i == 12'h050 |-> pslverr_o)
        else $error("unused paged slot did not error");
    fiber_upd_a: assert property (
        $changed(fiber_mode_enable_o) |-> $past(soft_reset_i)
            || $past(sys_rst_i, 2))
        else $error("fiber mode changed without soft reset");
endmodule

// ==== pcscs_regs_tb_top.sv ====
/*
 * self-checking bench of the pcs configuration register bank.
 * assumes: zero-wait apb slave; short watchdog and crossover counts.
 */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin \
    $display("MISMATCH %s exp %h got %h", n, e, s); \
    n_mismatch++; end end

module pcscs_regs_tb_top;
    localparam int SHORT = 20;
    localparam int LONG = 40;
    logic clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, strap = 1, soft_rst = 0, an_en = 0, mdix_en = 0;
    logic mac_i = 0, level_i = 0, lock_i = 0, idle_i = 1, p;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, r;
    logic [3:0] pstrb_i = 4'hf;
    logic pready_o, pslverr_o, mdix_o, free_o, silent_o, sd_o, long_o;
    logic fiber_o, force_o, fault_o, nrzi_o, tx_skip_o, rx_skip_o, link_o;
    logic [15:0] v;
    logic [32:0] ex;
    logic [32:0] expq[$];
    int n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 79, t, lim;

    pcscs_regs #(.DESC_SHORT_CYC(SHORT), .DESC_LONG_CYC(LONG),
        .XOVER_CYC(8)) uut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .fiber_strap_i(strap),
        .soft_reset_i(soft_rst), .autoneg_enable_i(an_en),
        .auto_mdix_enable_i(mdix_en), .mac_side_link_force_input_i(mac_i),
        .signal_level_valid_i(level_i), .descr_lock_i(lock_i),
        .descr_idle_seen_i(idle_i), .mdix_select_o(mdix_o),
        .rx_clk_free_run_o(free_o), .tx_silent_mode_enable_o(silent_o),
        .signal_detect_o(sd_o), .descrambler_timeout_long_o(long_o),
        .fiber_mode_enable_o(fiber_o), .force_100_link_o(force_o),
        .far_fault_indication_enable_o(fault_o), .nrzi_bypass_o(nrzi_o),
        .tx_whitening_skip_o(tx_skip_o), .rx_dewhitening_skip_o(rx_skip_o),
        .link_up_o(link_o));

    always #2 clk_i = ~clk_i;

    task automatic summarize();
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    // mid-cycle compare of each access against the oldest note
    always @(negedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && expq.size() > 0) begin
            ex = expq.pop_front();
            `CHK("pslverr", ex[32], pslverr_o)
            if (!pwrite_i) `CHK("prdata", ex[31:0], prdata_o)
        end
    end

    // one apb transfer; request held until pready at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [32:0] e);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        expq.push_back(e);
        @(posedge clk_i);
        penable_i <= 1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
    endtask

    task automatic idle(input int n);
        psel_i <= 0;
        penable_i <= 0;
        repeat (n) @(posedge clk_i);
    endtask

    task automatic chk_out(input logic [15:0] c);
        `CHK("free_clk", c[11], free_o)
        `CHK("silent", c[10], silent_o)
        `CHK("desc_long", c[7], long_o)
        `CHK("far_fault", c[3], fault_o)
        `CHK("nrzi", c[2], nrzi_o)
        `CHK("tx_skip", c[1], tx_skip_o)
        `CHK("rx_skip", c[0], rx_skip_o)
        `CHK("sd", c[9] | level_i, sd_o)
        `CHK("force", c[5] | mac_i, force_o)
    endtask

    task automatic link_is(input logic e, input int n);
        repeat (n) @(posedge clk_i);
        `CHK("link", e, link_o)
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 0;
        repeat (2) @(posedge clk_i);
        // strap high: fiber defaults on top of the plain reset value
        apb(0, 12'h058, 0, 33'h014b);
        apb(0, 12'h04c, 0, 33'h0);
        apb(0, 12'h000, 0, {1'b1, 32'h0});
        idle(1);
        `CHK("fiber", 1'b1, fiber_o)
        chk_out(16'h014b);
        // random settings read back, bit 4 always low
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            r[14:12] = 3'h0;
            level_i <= r[16];
            mac_i <= r[17];
            apb(1, 12'h058, r, 33'h0);
            v = r[15:0] & 16'hffef;
            apb(0, 12'h058, 0, {17'h0, v});
            idle(2);
            chk_out(v);
        end
        // low lane only; back-to-back transfers
        apb(1, 12'h058, 0, 33'h0);
        pstrb_i <= 4'h1;
        apb(1, 12'h058, 32'hffff, 33'h0);
        pstrb_i <= 4'hf;
        apb(0, 12'h058, 0, 33'h00ef);
        // page 2 hides the word; writes there are dropped
        apb(1, 12'h04c, 32'h2, 33'h0);
        apb(0, 12'h04c, 0, 33'h2);
        apb(1, 12'h058, 32'hffff, {1'b1, 32'h0});
        apb(0, 12'h058, 0, {1'b1, 32'h0});
        apb(1, 12'h04c, 0, 33'h0);
        apb(0, 12'h050, 0, {1'b1, 32'h0});
        apb(0, 12'h058, 0, 33'h00ef);
        // fiber output waits for the soft reset pulse
        apb(1, 12'h058, 32'h0100, 33'h0);
        idle(2);
        `CHK("fiber_hold", 1'b1, fiber_o)
        soft_rst <= 1;
        @(posedge clk_i);
        soft_rst <= 0;
        repeat (2) @(posedge clk_i);
        `CHK("fiber_off", 1'b0, fiber_o)
        // hold policy one keeps link through lock loss
        mac_i <= 0;
        level_i <= 1;
        lock_i <= 1;
        link_is(1, 5);
        lock_i <= 0;
        link_is(1, 5);
        apb(1, 12'h058, 0, 33'h0);
        idle(1);
        link_is(0, 4);
        lock_i <= 1;
        link_is(1, 5);
        level_i <= 0;
        link_is(0, 5);
        // no idles: timeout drops the link, short then long
        for (int m = 0; m < 2; m++) begin
            lim = m ? LONG : SHORT;
            lock_i <= 0;
            level_i <= 1;
            apb(1, 12'h058, m ? 32'h0080 : 32'h0, 33'h0);
            idle(3);
            idle_i <= 0;
            lock_i <= 1;
            link_is(1, lim - 6);
            link_is(0, 12);
        end
        // forced crossover hunts while the link is down
        level_i <= 0;
        lock_i <= 0;
        idle_i <= 1;
        apb(1, 12'h058, 32'h8000, 33'h0);
        idle(2);
        for (int k = 0; k < 2; k++) begin
            t = 0;
            p = mdix_o;
            repeat (40) begin
                @(posedge clk_i);
                if (mdix_o !== p) t++;
                p = mdix_o;
            end
            `CHK("xover", k == 0, t >= 4 && t <= 5)
            an_en <= 1;
        end
        an_en <= 0;
        apb(1, 12'h058, 0, 33'h0);
        idle(2);
        `CHK("mdix_off", 1'b0, mdix_o)
        summarize();
    end
endmodule

bind pcscs_regs pcscs_regs_assertions chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .soft_reset_i(soft_reset_i),
    .autoneg_enable_i(autoneg_enable_i),
    .auto_mdix_enable_i(auto_mdix_enable_i),
    .mac_side_link_force_input_i(mac_side_link_force_input_i),
    .signal_level_valid_i(signal_level_valid_i),
    .descr_lock_i(descr_lock_i), .mdix_select_o(mdix_select_o),
    .rx_clk_free_run_o(rx_clk_free_run_o),
    .tx_silent_mode_enable_o(tx_silent_mode_enable_o),
    .signal_detect_o(signal_detect_o),
    .fiber_mode_enable_o(fiber_mode_enable_o),
    .force_100_link_o(force_100_link_o),
    .rx_dewhitening_skip_o(rx_dewhitening_skip_o), .link_up_o(link_up_o));
